// ### bench/compare_sleep_subtract_exec_tb_top.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`include "cssx_defines.vh"
module compare_sleep_subtract_exec_tb_top;
    localparam PER = 8;
    reg         hclk;
    reg         hresetn;
    reg         hsel;
    reg  [31:0] haddr;
    reg  [1:0]  htrans;
    reg         hwrite;
    reg  [31:0] hwdata;
    reg         prog_mode;
    reg         wake_req;
    wire        hreadyout;
    wire        hresp;
    wire [31:0] hrdata;
    wire        osc_stop;
    wire        wdt_reset;
    wire        irq;
    reg         rd_dp;
    integer     mismatches;
    integer     checked;
    integer     cycles;
    integer     seed;
    integer     i;
    integer     n;
    reg  [31:0] rnd;
    reg  [8:0]  full;
    reg  [4:0]  hc;
    reg  [4:0]  flg;
    reg  [11:0] fad;
    reg  [31:0] exp_q[$];
    reg  [31:0] msk_q[$];
    reg  [11:0] adr_q[$];

    cssx_core #(.WDT_PERIOD(PER), .FILE_AW(6)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_mode(prog_mode),
        .wake_req(wake_req), .osc_stop(osc_stop), .wdt_reset(wdt_reset), .irq(irq));

    always #12.5 hclk = ~hclk;

    task report_and_stop;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // Cycle budget, and read data phase tracking for the monitor
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
        if (hreadyout)
            rd_dp <= hsel && htrans[1] && !hwrite;
    end

    // Read data taken at the edge that closes its data phase
    always @(posedge hclk) begin
        if (rd_dp && hreadyout && exp_q.size() > 0)
            chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(),
                hrdata & msk_q.pop_front());
    end

    // Called just after a rising edge; holds each phase until ready
    task bus(input reg wr, input [11:0] ad, input [31:0] dt);
        begin
            hsel <= 1'b1;
            haddr <= {20'h0, ad};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge hclk);
            while (!hreadyout) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= dt;
            @(posedge hclk);
            while (!hreadyout) @(posedge hclk);
        end
    endtask

    task rd(input [11:0] ad, input [31:0] ex, input [31:0] m);
        begin
            exp_q.push_back(ex & m);
            msk_q.push_back(m);
            adr_q.push_back(ad);
            bus(1'b0, ad, 32'h0);
        end
    endtask

    // Instruction write, then the fixed four-phase execution time
    task ex(input [15:0] op);
        begin
            bus(1'b1, `CSSX_A_INSTR, {16'h0, op});
            repeat (5) @(posedge hclk);
        end
    endtask

    task wdt_gap(output integer g);
        begin
            g = 0;
            @(negedge hclk);
            while (!wdt_reset) @(negedge hclk);
            @(negedge hclk);
            while (!wdt_reset) begin
                g = g + 1;
                @(negedge hclk);
            end
            g = g + 1;
            @(posedge hclk);
        end
    endtask

    task wait_wake(output integer k);
        begin
            k = 0;
            while (osc_stop === 1'b1 && k < 40) begin
                @(negedge hclk);
                k = k + 1;
            end
            @(posedge hclk);
        end
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        prog_mode = 1'b1;
        wake_req = 1'b0;
        rd_dp = 1'b0;
        mismatches = 0;
        checked = 0;
        cycles = 0;
        seed = 32'hD2DDCC66;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, instruction word ignored, one unmapped word
        for (i = 0; i < 11; i = i + 1)
            rd({i[9:0], 2'h0}, (i == 0) ? 32'h0F : (i == 1) ? 32'h1C : 32'h0,
               (i == 6) ? 32'hFFFF0000 : 32'hFFFFFFFF);
        bus(1'b1, `CSSX_A_IRQM, 32'h0F);
        for (i = 0; i < 4; i = i + 3) begin
            bus(1'b1, `CSSX_A_CFG, {28'h0, i[2:0], 1'b1});
            wdt_gap(n);
            chk("wdt gap", PER << i, n);
        end
        // Config disable: silent until the soft enable is set
        bus(1'b1, `CSSX_A_CFG, 32'h0);
        bus(1'b1, `CSSX_A_WDTC, 32'h0);
        n = 0;
        repeat (64) begin
            @(negedge hclk);
            n = n + wdt_reset;
        end
        @(posedge hclk);
        chk("wdt off", 0, n);
        bus(1'b1, `CSSX_A_WDTC, 32'h1);
        wdt_gap(n);
        chk("wdt soft", PER, n);
        bus(1'b1, `CSSX_A_WDTC, 32'h0);
        chk("irq set", 1, {31'h0, irq});
        rd(`CSSX_A_IRQS, 32'h04, 32'h04);
        @(negedge hclk);
        chk("irq clear", 0, {31'h0, irq});
        @(posedge hclk);
        // Programming window closes; read-only cause bits survive
        prog_mode <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b1, `CSSX_A_CFG, 32'h0F);
        rd(`CSSX_A_CFG, 32'h0, 32'hFF);
        bus(1'b1, `CSSX_A_RESET_CAUSE_CONTROL, 32'h0);
        rd(`CSSX_A_RESET_CAUSE_CONTROL, 32'h04, 32'hFF);
        for (i = 0; i < 12; i = i + 1) begin
            rnd = $random(seed);
            fad = 12'h400 | {4'h0, rnd[25:20], 2'h0};
            bus(1'b1, `CSSX_A_WREG, {24'h0, rnd[7:0]});
            bus(1'b1, fad, {24'h0, rnd[15:8]});
            bus(1'b1, `CSSX_A_STAT, {31'h0, rnd[16]});
            ex({`CSSX_OP_SUB, rnd[17], rnd[18], 2'h0, rnd[25:20]});
            full = {1'b0, rnd[7:0]} - {1'b0, rnd[15:8]} - {8'h0, !rnd[16]};
            hc = {1'b0, rnd[3:0]} - {1'b0, rnd[11:8]} - {4'h0, !rnd[16]};
            flg = {full[7], (rnd[7] != rnd[15]) && (full[7] != rnd[7]),
                   full[7:0] == 8'h0, !hc[4], !full[8]};
            rd(`CSSX_A_WREG, {24'h0, rnd[17] ? rnd[7:0] : full[7:0]}, 32'hFF);
            rd(fad, {24'h0, rnd[17] ? full[7:0] : rnd[15:8]}, 32'hFF);
            rd(`CSSX_A_STAT, {27'h0, flg}, 32'h1F);
        end
        // Unequal, equal, equal followed by a two-word instruction
        for (i = 0; i < 3; i = i + 1) begin
            bus(1'b1, `CSSX_A_WREG, 32'h55);
            bus(1'b1, 12'h404, (i == 0) ? 32'h33 : 32'h55);
            bus(1'b1, `CSSX_A_STAT, 32'h1F);
            ex({`CSSX_OP_CMP, i[0], 8'h01});
            rd(`CSSX_A_STAT, 32'h1F, 32'h1F);
            if (i == 2)
                ex(16'hC001);
            ex({`CSSX_OP_SUB, 2'h0, 8'h01});
            rd(`CSSX_A_WREG, (i == 0) ? 32'h22 : 32'h55, 32'hFF);
        end
        rd(`CSSX_A_IRQS, 32'h03, 32'h03);
        ex(`CSSX_OP_SLEEP);
        @(negedge hclk);
        chk("asleep", 1, {31'h0, osc_stop});
        @(posedge hclk);
        rd(`CSSX_A_RESET_CAUSE_CONTROL, 32'h08, 32'h0C);
        wake_req <= 1'b1;
        wait_wake(n);
        wake_req <= 1'b0;
        chk("awake", 0, {31'h0, osc_stop});
        rd(`CSSX_A_RESET_CAUSE_CONTROL, 32'h08, 32'h0C);
        rd(`CSSX_A_IRQS, 32'h09, 32'h0F);
        // Watchdog wake: count starts from zero at sleep entry
        bus(1'b1, `CSSX_A_WDTC, 32'h1);
        ex(`CSSX_OP_SLEEP);
        wait_wake(n);
        bus(1'b1, `CSSX_A_WDTC, 32'h0);
        chk("sleep span", 1, {31'h0, n > 2 && n < 12});
        rd(`CSSX_A_RESET_CAUSE_CONTROL, 32'h00, 32'h0C);
        // Mask hides a pending event until unmasked
        bus(1'b1, `CSSX_A_IRQM, 32'h0);
        rd(`CSSX_A_IRQS, 32'h0D, 32'h0F);
        ex({`CSSX_OP_SUB, 2'h0, 8'h02});
        chk("irq masked", 0, {31'h0, irq});
        bus(1'b1, `CSSX_A_IRQM, 32'h01);
        @(negedge hclk);
        chk("irq unmasked", 1, {31'h0, irq});
        @(posedge hclk);
        rd(`CSSX_A_IRQS, 32'h01, 32'h01);
        repeat (2) @(posedge hclk);
        chk("irq read", 0, {31'h0, irq});
        chk("hresp", 0, {31'h0, hresp});
        report_and_stop;
    end
endmodule

// ### bench/cssx_core_sva.sv
// Port-level assertion checker for the execution core
`timescale 1ns/1ps
module cssx_core_sva #(
    parameter WDT_PERIOD = 8,
    parameter FILE_AW    = 6
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        prog_mode,
    input wire        wake_req,
    input wire        osc_stop,
    input wire        wdt_reset,
    input wire        irq
);
    reg  wr_dp_ff;
    wire nxt_wr_dp;

    // Write data phase tracker; a stall is legal only inside one
    assign nxt_wr_dp = hready ? (hsel && htrans[1] && hwrite) : wr_dp_ff;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wr_dp_ff <= 1'b0;
        else
            wr_dp_ff <= nxt_wr_dp;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_addr;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    // Sleep word taken in an unstalled data phase while awake
    sequence s_sleep_acc;
        hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h018
        ##1 hready && hwdata[15:0] == 16'h0003 && !osc_stop;
    endsequence

    a_sleep_stops_osc: assert property (s_sleep_acc |=> !osc_stop[*3] ##[1:3] osc_stop)
        else $error("oscillator stop not four cycles after sleep");
    a_sleep_clears_wdt: assert property ($rose(osc_stop) |-> !wdt_reset[*8])
        else $error("watchdog pulse too soon after sleep");
    a_wdt_one_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog pulse longer than one cycle");
    a_wake_on_req: assert property (osc_stop && wake_req |-> ##[1:4] !osc_stop)
        else $error("no wake after wake request");
    a_rd_upper_zero: assert property (s_rd_addr ##0 haddr[11:0] != 12'h018
        |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (s_rd_addr ##0 (haddr[11:10] == 2'h0 &&
        haddr[9:0] >= 10'h028) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_stall_in_write: assert property (!hreadyout |-> wr_dp_ff)
        else $error("stall outside write data phase");
    a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite)
        |=> $stable(hrdata))
        else $error("read data changed without read");
endmodule

bind cssx_core cssx_core_sva #(.WDT_PERIOD(WDT_PERIOD), .FILE_AW(FILE_AW)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_mode(prog_mode),
    .wake_req(wake_req), .osc_stop(osc_stop), .wdt_reset(wdt_reset), .irq(irq));

// ### rtl/cssx_core.v
// Execution core for compare-skip, sleep and subtract-with-borrow
//
// Summary of operation
// - watchdog time-out passes through a postscaler
// - postscale select fixed by programming-time config
// - unscaled watchdog period nominally 18 ms
// - instruction cycle is four clocks, four phases
// - compare file with W unsigned, flags untouched
// - equal compare discards next word(s) as NOPs
// - sleep clears watchdog, sets TO, clears PD
// - subtract destination bit picks W or file
// - access bit picks access bank or bank select
`timescale 1ns/1ps
`include "cssx_defines.vh"
module cssx_core #(
    parameter WDT_PERIOD = `CSSX_WDT_NOM_CYC,
    parameter FILE_AW    = 6
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        prog_mode,
    input  wire        wake_req,
    output wire        osc_stop,
    output wire        wdt_reset,
    output wire        irq
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_RUN   = 2'd1;
    localparam [1:0] ST_SLEEP = 2'd2;
    localparam [1:0] Q4       = 2'd3;

    reg  [7:0]  cfg_ff;
    reg  [7:0]  reset_cause_control_ff;
    reg         wdtc_ff;
    reg  [7:0]  w_ff;
    reg  [4:0]  stat_ff;
    reg  [3:0]  bsr_ff;
    reg  [15:0] instr_ff;
    reg         nop_ff;
    reg         disc_ff;
    reg         tail_ff;
    reg  [1:0]  state_ff;
    reg  [1:0]  phase_ff;
    reg  [7:0]  fdat_ff;
    reg  [7:0]  res_ff;
    reg  [4:0]  flg_ff;
    reg         eq_ff;
    reg  [3:0]  irqs_ff;
    reg  [3:0]  irqm_ff;
    reg  [31:0] hrdata_ff;
    reg         dp_val_ff;
    reg         dp_wr_ff;
    reg  [11:0] dp_addr_ff;
    reg         prog_s1_ff;
    reg         prog_s2_ff;
    reg         wake_s1_ff;
    reg         wake_s2_ff;
    reg         wdt_rst_ff;
    reg  [31:0] nxt_rdata;
    reg  [3:0]  nxt_ev;

    wire        ap;
    wire        busy;
    wire        stall;
    wire        dp_wr;
    wire        dp_file;
    wire        core_reg;
    wire        is_cmp;
    wire        is_sub;
    wire        is_slp;
    wire        q4_go;
    wire        ex_we;
    wire        bus_fwe;
    wire        instr_acc;
    wire        two_word;
    wire        wdt_en;
    wire        wdt_tmo;
    wire        slp_go;
    wire [7:0]  fsel;
    wire [11:0] faddr;
    wire [8:0]  diff;
    wire [4:0]  dlo;
    wire [7:0]  rd_ex;
    wire [7:0]  rd_bus;

    // Address phase is taken only when the bus is ready
    assign ap       = hsel && hready && htrans[1];
    assign busy     = (state_ff != ST_IDLE);
    assign dp_wr    = dp_val_ff && dp_wr_ff;
    assign dp_file  = (dp_addr_ff[11:10] == `CSSX_A_FILE);
    assign core_reg = (dp_addr_ff == `CSSX_A_WREG) || (dp_addr_ff == `CSSX_A_STAT) ||
                      (dp_addr_ff == `CSSX_A_BSR) || (dp_addr_ff == `CSSX_A_INSTR);

    // Stall instead of losing a write that collides with execution
    assign stall     = dp_wr && ((core_reg && busy) || (dp_file && ex_we));
    assign hreadyout = !stall;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    // Decode of the held instruction word
    assign is_cmp = !nop_ff && (instr_ff[15:9] == `CSSX_OP_CMP);
    assign is_sub = !nop_ff && (instr_ff[15:10] == `CSSX_OP_SUB);
    assign is_slp = !nop_ff && (instr_ff == `CSSX_OP_SLEEP);
    assign q4_go  = (state_ff == ST_RUN) && (phase_ff == Q4);
    assign slp_go = q4_go && is_slp;

    // Access bank splits at 0x80: low half bank 0, high half bank 15
    assign fsel  = instr_ff[7:0];
    assign faddr = instr_ff[8] ? {bsr_ff, fsel} :
                   {(fsel[7] ? `CSSX_ACC_HI : 4'h0), fsel};

    // Borrow is the inverse of carry
    assign diff = {1'b0, w_ff} - {1'b0, fdat_ff} - {8'h00, ~stat_ff[`CSSX_ST_C]};
    assign dlo  = {1'b0, w_ff[3:0]} - {1'b0, fdat_ff[3:0]} -
                  {4'h0, ~stat_ff[`CSSX_ST_C]};

    assign ex_we   = q4_go && is_sub && instr_ff[9];
    assign bus_fwe = dp_wr && dp_file && !stall;

    // Word following a taken skip; long forms carry a second word
    assign instr_acc = dp_wr && !stall && (dp_addr_ff == `CSSX_A_INSTR);
    assign two_word  = (hwdata[15:12] == `CSSX_OP_MOVFF) ||
                       ((hwdata[15:12] == `CSSX_OP_LONG) && (hwdata[11:10] == 2'b11));

    assign wdt_en    = cfg_ff[`CSSX_CFG_EN] || wdtc_ff;
    assign osc_stop  = (state_ff == ST_SLEEP);
    assign wdt_reset = wdt_rst_ff;
    assign irq       = |(irqs_ff & irqm_ff);

    cssx_file_ram #(
        .AW      (FILE_AW)
    ) u_ram (
        .hclk    (hclk),
        .hresetn (hresetn),
        .we      (ex_we || bus_fwe),
        .waddr   (ex_we ? faddr[FILE_AW-1:0] : dp_addr_ff[FILE_AW+1:2]),
        .wdata   (ex_we ? res_ff : hwdata[7:0]),
        .raddr_a (faddr[FILE_AW-1:0]),
        .rdata_a (rd_ex),
        .raddr_b (haddr[FILE_AW+1:2]),
        .rdata_b (rd_bus)
    );

    cssx_watchdog #(
        .PERIOD  (WDT_PERIOD)
    ) u_wdt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (wdt_en),
        .clear   (slp_go),
        .ps_sel  (cfg_ff[3:1]),
        .tmo_ff  (wdt_tmo)
    );

    // Pin inputs pass two flip-flops before use
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_s1_ff <= 1'b0;
            prog_s2_ff <= 1'b0;
            wake_s1_ff <= 1'b0;
            wake_s2_ff <= 1'b0;
        end else begin
            prog_s1_ff <= prog_mode;
            prog_s2_ff <= prog_s1_ff;
            wake_s1_ff <= wake_req;
            wake_s2_ff <= wake_s1_ff;
        end
    end

    // Read mux for the address phase
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (haddr[11:0])
            `CSSX_A_CFG:   nxt_rdata[7:0]  = cfg_ff;
            `CSSX_A_RESET_CAUSE_CONTROL:  nxt_rdata[7:0]  = reset_cause_control_ff;
            `CSSX_A_WDTC:  nxt_rdata[0]    = wdtc_ff;
            `CSSX_A_WREG:  nxt_rdata[7:0]  = w_ff;
            `CSSX_A_STAT:  nxt_rdata[4:0]  = stat_ff;
            `CSSX_A_BSR:   nxt_rdata[3:0]  = bsr_ff;
            `CSSX_A_INSTR: nxt_rdata[15:0] = instr_ff;
            `CSSX_A_EXEC:  nxt_rdata[3:0]  = {tail_ff, disc_ff, osc_stop, busy};
            `CSSX_A_IRQS:  nxt_rdata[3:0]  = irqs_ff;
            `CSSX_A_IRQM:  nxt_rdata[3:0]  = irqm_ff;
            default: begin
                if (haddr[11:10] == `CSSX_A_FILE) begin
                    nxt_rdata[7:0] = rd_bus;
                end
            end
        endcase
    end

    // Bus pipeline: capture address phase, register read data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_val_ff  <= 1'b0;
            dp_wr_ff   <= 1'b0;
            dp_addr_ff <= 12'h000;
            hrdata_ff  <= 32'h0000_0000;
        end else if (hready) begin
            dp_val_ff  <= ap;
            dp_wr_ff   <= hwrite;
            dp_addr_ff <= haddr[11:0];
            if (ap && !hwrite) begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    // Software registers; config writes only while programming
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff  <= `CSSX_CFG_RST;
            wdtc_ff <= 1'b0;
            irqm_ff <= 4'h0;
        end else if (dp_wr && !stall) begin
            if ((dp_addr_ff == `CSSX_A_CFG) && prog_s2_ff) begin
                cfg_ff <= hwdata[7:0];
            end
            if (dp_addr_ff == `CSSX_A_WDTC) begin
                wdtc_ff <= hwdata[0];
            end
            if (dp_addr_ff == `CSSX_A_IRQM) begin
                irqm_ff <= hwdata[3:0];
            end
        end
    end

    // Event collection for the sticky status
    always @* begin
        nxt_ev = 4'h0;
        nxt_ev[`CSSX_EV_DONE] = q4_go;
        nxt_ev[`CSSX_EV_SKIP] = q4_go && is_cmp && eq_ff;
        nxt_ev[`CSSX_EV_WDT]  = wdt_tmo;
        nxt_ev[`CSSX_EV_WAKE] = osc_stop && (wdt_tmo || wake_s2_ff);
    end

    // Read clears, but an event in the same cycle still sets
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqs_ff <= 4'h0;
        end else if (ap && !hwrite && (haddr[11:0] == `CSSX_A_IRQS)) begin
            irqs_ff <= nxt_ev;
        end else begin
            irqs_ff <= irqs_ff | nxt_ev;
        end
    end

    // Reset cause flags: hardware owns time-out and power-down
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_cause_control_ff    <= `CSSX_RESET_CAUSE_CONTROL_RST;
            wdt_rst_ff <= 1'b0;
        end else begin
            wdt_rst_ff <= wdt_tmo && !osc_stop;
            if (dp_wr && (dp_addr_ff == `CSSX_A_RESET_CAUSE_CONTROL)) begin
                reset_cause_control_ff <= (reset_cause_control_ff & ~`CSSX_RESET_CAUSE_CONTROL_WM) | (hwdata[7:0] & `CSSX_RESET_CAUSE_CONTROL_WM);
            end
            if (slp_go) begin
                reset_cause_control_ff[`CSSX_RC_TO] <= 1'b1;
                reset_cause_control_ff[`CSSX_RC_PD] <= 1'b0;
            end else if (wdt_tmo) begin
                reset_cause_control_ff[`CSSX_RC_TO] <= 1'b0;
                reset_cause_control_ff[`CSSX_RC_PD] <= !osc_stop;
            end
        end
    end

    // Sequencer: one instruction cycle is four phases
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
            phase_ff <= 2'd0;
            instr_ff <= 16'h0000;
            nop_ff   <= 1'b0;
            disc_ff  <= 1'b0;
            tail_ff  <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (instr_acc) begin
                        instr_ff <= hwdata[15:0];
                        nop_ff   <= disc_ff || tail_ff;
                        phase_ff <= 2'd0;
                        state_ff <= ST_RUN;
                        if (tail_ff) begin
                            tail_ff <= 1'b0;
                        end else if (disc_ff) begin
                            disc_ff <= 1'b0;
                            tail_ff <= two_word;
                        end
                    end
                end
                ST_RUN: begin
                    phase_ff <= phase_ff + 2'd1;
                    if (phase_ff == Q4) begin
                        state_ff <= is_slp ? ST_SLEEP : ST_IDLE;
                        if (is_cmp && eq_ff) begin
                            disc_ff <= 1'b1;
                        end
                    end
                end
                ST_SLEEP: begin
                    // Oscillator held off until a wake source
                    if (wdt_tmo || wake_s2_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Q2 reads the operand, Q3 computes, Q4 writes back
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fdat_ff <= 8'h00;
            res_ff  <= 8'h00;
            flg_ff  <= 5'h00;
            eq_ff   <= 1'b0;
        end else if (state_ff == ST_RUN) begin
            if (phase_ff == 2'd1) begin
                fdat_ff <= rd_ex;
            end
            if (phase_ff == 2'd2) begin
                res_ff <= diff[7:0];
                eq_ff  <= (fdat_ff == w_ff);
                flg_ff[`CSSX_ST_C]  <= !diff[8];
                flg_ff[`CSSX_ST_DC] <= !dlo[4];
                flg_ff[`CSSX_ST_Z]  <= (diff[7:0] == 8'h00);
                flg_ff[`CSSX_ST_N]  <= diff[7];
                flg_ff[`CSSX_ST_OV] <= (w_ff[7] != fdat_ff[7]) && (diff[7] != w_ff[7]);
            end
        end
    end

    // Working register, status flags and bank select
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_ff    <= 8'h00;
            stat_ff <= 5'h00;
            bsr_ff  <= 4'h0;
        end else if (q4_go) begin
            if (is_sub) begin
                stat_ff <= flg_ff;
                if (!instr_ff[9]) begin
                    w_ff <= res_ff;
                end
            end
        end else if (dp_wr && !stall) begin
            if (dp_addr_ff == `CSSX_A_WREG) begin
                w_ff <= hwdata[7:0];
            end
            if (dp_addr_ff == `CSSX_A_STAT) begin
                stat_ff <= hwdata[4:0];
            end
            if (dp_addr_ff == `CSSX_A_BSR) begin
                bsr_ff <= hwdata[3:0];
            end
        end
    end
endmodule

// ### rtl/cssx_defines.vh
// Constants for the compare, sleep and subtract execution block
`ifndef CSSX_DEFINES_VH
`define CSSX_DEFINES_VH

// Timing
`define CSSX_CLK_KHZ      40000
`define CSSX_QPHASES      4
`define CSSX_WDT_MIN_MS   7
`define CSSX_WDT_NOM_MS   18
`define CSSX_WDT_MAX_MS   33
`define CSSX_WDT_NOM_CYC  (`CSSX_WDT_NOM_MS * `CSSX_CLK_KHZ)

// Register byte offsets
`define CSSX_A_CFG    12'h000
`define CSSX_A_RESET_CAUSE_CONTROL   12'h004
`define CSSX_A_WDTC   12'h008
`define CSSX_A_WREG   12'h00C
`define CSSX_A_STAT   12'h010
`define CSSX_A_BSR    12'h014
`define CSSX_A_INSTR  12'h018
`define CSSX_A_EXEC   12'h01C
`define CSSX_A_IRQS   12'h020
`define CSSX_A_IRQM   12'h024
`define CSSX_A_FILE   2'h1

// Reset values and writable masks
`define CSSX_CFG_RST   8'h0F
`define CSSX_RESET_CAUSE_CONTROL_RST  8'h1C
`define CSSX_RESET_CAUSE_CONTROL_WM   8'h93

// Field positions
`define CSSX_CFG_EN    0
`define CSSX_RC_TO     3
`define CSSX_RC_PD     2
`define CSSX_ST_C      0
`define CSSX_ST_DC     1
`define CSSX_ST_Z      2
`define CSSX_ST_OV     3
`define CSSX_ST_N      4
`define CSSX_EV_DONE   0
`define CSSX_EV_SKIP   1
`define CSSX_EV_WDT    2
`define CSSX_EV_WAKE   3

// Opcodes
`define CSSX_OP_SLEEP  16'h0003
`define CSSX_OP_CMP    7'h31
`define CSSX_OP_SUB    6'h15
`define CSSX_OP_MOVFF  4'hC
`define CSSX_OP_LONG   4'hE
`define CSSX_ACC_HI    4'hF

`endif

// ### rtl/cssx_file_ram.v
// File register storage, one write port and two read ports
`timescale 1ns/1ps
module cssx_file_ram #(
    parameter AW = 6
) (
    input  wire          hclk,
    input  wire          hresetn,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [7:0]    wdata,
    input  wire [AW-1:0] raddr_a,
    output wire [7:0]    rdata_a,
    input  wire [AW-1:0] raddr_b,
    output wire [7:0]    rdata_b
);
    localparam DEPTH = 1 << AW;

    wire [7:0] mem [0:DEPTH-1];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
            reg [7:0] ent_ff;
            // Each entry loads only on its own address
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ent_ff <= 8'h00;
                end else if (we && (waddr == gi)) begin
                    ent_ff <= wdata;
                end
            end
            assign mem[gi] = ent_ff;
        end
    endgenerate

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule

// ### rtl/cssx_watchdog.v
// Watchdog timer with base period counter and postscaler
`timescale 1ns/1ps
`include "cssx_defines.vh"
module cssx_watchdog #(
    parameter PERIOD = `CSSX_WDT_NOM_CYC,
    parameter CW     = 20
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        enable,
    input  wire        clear,
    input  wire [2:0]  ps_sel,
    output reg         tmo_ff
);
    localparam [31:0] PM1 = PERIOD - 1;

    reg  [CW-1:0] base_ff;
    reg  [6:0]    post_ff;
    wire          base_wrap;
    wire [6:0]    post_lim;

    // Postscale limit is 2^sel - 1 base periods
    assign base_wrap = (base_ff == PM1[CW-1:0]);
    assign post_lim  = ~(7'h7F << ps_sel);

    // Clear and disable both restart the whole chain
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_ff <= {CW{1'b0}};
            post_ff <= 7'h00;
            tmo_ff  <= 1'b0;
        end else if (clear || !enable) begin
            base_ff <= {CW{1'b0}};
            post_ff <= 7'h00;
            tmo_ff  <= 1'b0;
        end else begin
            tmo_ff <= 1'b0;
            if (base_wrap) begin
                base_ff <= {CW{1'b0}};
                if (post_ff == post_lim) begin
                    post_ff <= 7'h00;
                    tmo_ff  <= 1'b1;
                end else begin
                    post_ff <= post_ff + 7'h01;
                end
            end else begin
                base_ff <= base_ff + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
